/* File: hfadc_host.sv */
/*
 host sequencer for an 8-bit two-step flash converter, driving its chip
 select, read and write strobes and capturing data, done and overrange.
 assumes the converter's mode strap is wired to the same level as modeHigh
 and that converter pins arrive asynchronously to ref_clk.
*/
// Operation
// RULE1: strap low read mode, high write-read
// RULE2: read mode: hold read low until done
// RULE3: converter times two 800 ns phases
// RULE4: done low ends conversion, ready shows busy
// RULE5: write strobe low starts conversion
// RULE6: write strobe low at least 600 ns
// RULE7: read no sooner than 600 ns later
// RULE8: done falls about 800 ns after write
// RULE9: early read forces done, presents data
// RULE10: stand-alone: pulse write, data after 800 ns
// RULE11: write strobe low at most 50 us
// RULE12: wait 500 ns re-zero between conversions
// RULE13: converter samples input during strobe low
// RULE14: extra comparator flags overrange
// RULE15: result is upper and lower nibbles
// RULE16: overrange low at end, always driven
// RULE17: data drives once read-mode conversion completes
// RULE18: phase timeouts counted on local clock
module hfadc_host #(
	parameter int WR_HOLD_CYC = hfadc_pkg::WR_LOW_CYC,
	parameter int RD_LIMIT_CYC = hfadc_pkg::RD_TIMEOUT_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic modeHigh,
	input wire hfadc_pkg::hfadc_req_s req,
	output logic busy,
	output hfadc_pkg::hfadc_res_s res,
	output hfadc_pkg::hfadc_pins_s pins,
	input wire logic [hfadc_pkg::DATA_W-1:0] resultBus,
	input wire logic doneN,
	input wire logic readyIn,
	input wire logic overrange_flag_n
);
	import hfadc_pkg::*;

	// ---------------------------------------------------------------
	// pin synchronisation
	// ---------------------------------------------------------------
	logic [DATA_W+1:0] syncIn;

	hfadc_sync #(.W(DATA_W + 2)) uSync (
		.ref_clk(ref_clk),
		.srst(srst),
		.async({resultBus, doneN, overrange_flag_n}),
		.clean(syncIn)
	);

	logic doneNs;
	logic ovfNs;
	logic [DATA_W-1:0] dataS;
	assign doneNs = syncIn[1];
	assign ovfNs = syncIn[0];
	assign dataS = syncIn[DATA_W+1:2];

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		hfadc_state_e fsm;
		logic [CNT_W-1:0] cnt;
		logic rdMode;
		logic early;
		logic busy;
		hfadc_res_s res;
		hfadc_pins_s pins;
		logic [CNT_W-1:0] lowLen;
		logic [CNT_W-1:0] sinceWr;
		logic [CNT_W-1:0] idleLen;
	} hfhost_s;

	hfhost_s st, next_st;

	// the bus only turns round once read falls, so data lags done
	logic dataSettled;
	assign dataSettled = (st.cnt <= CNT_W'(RD_LIMIT_CYC - SYNC_CYC));

	function automatic logic [CNT_W-1:0] hfadc_inc(
		input logic [CNT_W-1:0] c
	);
		hfadc_inc = (c == '1) ? c : c + CNT_W'(1);
	endfunction

	always_comb begin
		next_st = st;
		next_st.res.valid = 1'b0;
		next_st.cnt = hfadc_dec(st.cnt);
		unique case (st.fsm)
			HFA_IDLE: begin
				next_st.busy = 1'b0;
				if (req.start) begin
					// RULE1: mode follows strap
					next_st.rdMode = ~modeHigh;
					next_st.early = req.early;
					next_st.busy = 1'b1;
					next_st.res.timeout = 1'b0;
					next_st.pins.csN = 1'b0;
					if (modeHigh) begin
						// RULE5: write low starts
						next_st.pins.wrN = 1'b0;
						next_st.cnt = CNT_W'(WR_HOLD_CYC);
						next_st.fsm = HFA_WRLOW;
					end else begin
						// RULE2: read low starts
						next_st.pins.rdN = 1'b0;
						next_st.cnt = CNT_W'(RD_LIMIT_CYC);
						next_st.fsm = HFA_RDLOW;
					end
				end
			end
			HFA_WRLOW: begin
				// RULE6: hold write low
				// RULE11: well under the 50 us ceiling
				if (st.cnt == '0) begin
					next_st.pins.wrN = 1'b1;
					next_st.cnt = CNT_W'(RD_GAP_CYC);
					next_st.fsm = HFA_GAP;
				end
			end
			HFA_GAP: begin
				// RULE7: wait before read
				if (st.cnt == '0) begin
					if (st.early) begin
						// RULE9: early read
						next_st.pins.rdN = 1'b0;
						next_st.cnt = CNT_W'(RD_LIMIT_CYC);
						next_st.fsm = HFA_RDLOW;
					end else begin
						// RULE8: wait for done
						next_st.cnt = CNT_W'(RD_LIMIT_CYC);
						next_st.fsm = HFA_WAITDONE;
					end
				end
			end
			HFA_WAITDONE: begin
				// RULE10: data follows done
				if (!doneNs) begin
					next_st.pins.rdN = 1'b0;
					next_st.cnt = CNT_W'(RD_LIMIT_CYC);
					next_st.fsm = HFA_RDLOW;
				end else if (st.cnt == '0) begin
					next_st.fsm = HFA_FAULT;
				end
			end
			HFA_RDLOW: begin
				// RULE4: done low ends it
				// RULE17: data valid then
				if (!doneNs && dataSettled) begin
					// RULE15: both nibbles
					next_st.res.data = dataS;
					// RULE14: overrange flag
					// RULE16: captured at end
					next_st.res.overrange = ~ovfNs;
					next_st.res.valid = 1'b1;
					next_st.pins.rdN = 1'b1;
					next_st.pins.csN = 1'b1;
					next_st.cnt = CNT_W'(REZERO_CYC);
					next_st.fsm = HFA_REZERO;
				end else if (st.cnt == '0) begin
					next_st.fsm = HFA_FAULT;
				end
			end
			HFA_REZERO: begin
				// RULE12: re-zero gap
				if (st.cnt == '0) begin
					next_st.busy = 1'b0;
					next_st.fsm = HFA_IDLE;
				end
			end
			HFA_FAULT: begin
				// no answer from converter: release pins, report, re-zero
				next_st.pins = '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1};
				next_st.res.timeout = 1'b1;
				next_st.res.valid = 1'b1;
				next_st.cnt = CNT_W'(REZERO_CYC);
				next_st.fsm = HFA_REZERO;
			end
			default: begin
				next_st.fsm = HFA_IDLE;
			end
		endcase
		// write-low, since-write and chip-select idle lengths for the timing checks, saturating
		next_st.lowLen = next_st.pins.wrN ? '0 : hfadc_inc(st.lowLen);
		next_st.sinceWr = next_st.pins.wrN ? hfadc_inc(st.sinceWr) : '0;
		next_st.idleLen = next_st.pins.csN ? hfadc_inc(st.idleLen) : '0;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st <= '{fsm: HFA_IDLE, cnt: '0, rdMode: 1'b0, early: 1'b0,
				busy: 1'b0,
				res: '{valid: 1'b0, overrange: 1'b0, timeout: 1'b0,
				data: DATA_RST},
				pins: '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1},
				lowLen: '0, sinceWr: '1, idleLen: '1};
		end else begin
			st <= next_st;
		end
	end

	assign busy = st.busy;
	assign res = st.res;
	assign pins = st.pins;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	chk_wr_min_width: assert property ( // RULE6
		$rose(pins.wrN) |-> $past(st.lowLen) >= CNT_W'(WR_LOW_CYC)
	) else $error("write strobe released early");

	chk_wr_max_width: assert property ( // RULE11
		$fell(pins.wrN) |-> ##[1:40] pins.wrN
	) else $error("write strobe held too long");

	chk_rd_gap: assert property ( // RULE7
		$fell(pins.rdN) && !st.rdMode |-> st.sinceWr > CNT_W'(RD_GAP_CYC)
	) else $error("read too soon after write");

	chk_rezero_gap: assert property ( // RULE12
		$fell(pins.csN) |-> $past(st.idleLen) >= CNT_W'(REZERO_CYC)
	) else $error("new conversion inside re-zero");

	chk_rd_hold: assert property ( // RULE2
		(st.rdMode && st.fsm == HFA_RDLOW && doneNs) |=> !pins.rdN
	) else $error("read released before done");

	chk_cs_with_strobe: assert property ( // RULE5
		(!pins.wrN || !pins.rdN) |-> !pins.csN
	) else $error("strobe without chip select");

	chk_result_on_done: assert property ( // RULE15
		(st.fsm == HFA_RDLOW && !doneNs && dataSettled) |=>
			res.valid && res.data == $past(dataS)
	) else $error("result not taken at done");

	chk_mode_select: assert property ( // RULE1
		(st.fsm == HFA_IDLE && req.start) |=> !pins.csN &&
			(pins.wrN == !$past(modeHigh)) && (pins.rdN == $past(modeHigh))
	) else $error("wrong strobe for mode");

	cov_wr_rd: cover property ($fell(pins.wrN) ##[1:60] $fell(pins.rdN));
	cov_rd_mode: cover property (st.rdMode && res.valid);
	cov_overrange: cover property (res.valid && res.overrange);
	cov_timeout: cover property (res.timeout && res.valid);
endmodule

/* File: hfadc_pkg.sv */
/*
 package for the half-flash converter host sequencer: timing constants,
 state encoding and the request/result carriers.
 assumes a 20 MHz ref_clk shared by all users of this package.
*/
package hfadc_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int WR_LOW_MIN_NS = 600;
	localparam int RD_GAP_MIN_NS = 600;
	localparam int INT_WAIT_NS = 800;
	localparam int REZERO_MIN_NS = 500;
	localparam int WR_LOW_MAX_US = 50;
	localparam int RD_PHASE_NS = 800;
	// least times round up, longest times round down
	localparam int WR_LOW_CYC = (WR_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_GAP_CYC = (RD_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INT_WAIT_CYC = (INT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REZERO_CYC = (REZERO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_LOW_MAX_CYC = (WR_LOW_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int RD_TIMEOUT_CYC = (2 * RD_PHASE_NS) / CLK_PERIOD_NS * 2;
	localparam int CNT_W = 12;
	// pins pass three flops and then the agreement stage
	localparam int SYNC_CYC = 4;
	localparam int DATA_W = 8;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

	// ---------------------------------------------------------------
	// states
	// ---------------------------------------------------------------
	typedef enum logic [6:0] {
		HFA_IDLE = 7'h01,
		HFA_WRLOW = 7'h02,
		HFA_GAP = 7'h04,
		HFA_WAITDONE = 7'h08,
		HFA_RDLOW = 7'h10,
		HFA_REZERO = 7'h20,
		HFA_FAULT = 7'h40
	} hfadc_state_e;

	typedef struct packed {
		logic start;
		logic early;
	} hfadc_req_s;

	typedef struct packed {
		logic valid;
		logic overrange;
		logic timeout;
		logic [DATA_W-1:0] data;
	} hfadc_res_s;

	typedef struct packed {
		logic csN;
		logic rdN;
		logic wrN;
	} hfadc_pins_s;

	function automatic logic [CNT_W-1:0] hfadc_dec(input logic [CNT_W-1:0] c);
		hfadc_dec = (c == '0) ? '0 : c - 12'h001;
	endfunction
endpackage

/* File: hfadc_sync.sv */
/*
 three-stage input synchroniser with a filter that passes a change once stages two and three agree.
 assumes the input is asynchronous to ref_clk.
*/
module hfadc_sync #(
	parameter int W = 10
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [W-1:0] async,
	output logic [W-1:0] clean
);
	import hfadc_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] out;
	} hfsync_s;

	hfsync_s st, next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = async;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// a change is taken once stages two and three agree
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.out[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st <= '{s1: '1, s2: '1, s3: '1, out: '1};
		end else begin
			st <= next_st;
		end
	end

	assign clean = st.out;
endmodule

/* File: hfadc_model.sv */
/*
 behavioural two-step converter on the far side of the host.
 assumes ns time units and one conversion at a time.
*/
module hfadc_model (
	input wire hfadc_pkg::hfadc_pins_s pins,
	input wire logic modeHigh,
	input wire logic [8:0] analog,
	input var int phaseNs,
	output logic [7:0] resultBus,
	output logic doneN,
	output logic readyIn,
	output logic overrange_flag_n,
	output int faults
);
	timeunit 1ns;
	timeprecision 1ps;
	import hfadc_pkg::*;
	logic [7:0] held;
	logic over, pending;
	int id;
	realtime tWrFall, tWrRise, tEnd;
	initial begin
		{held, over, pending, id, faults} = '0;
		{doneN, readyIn, overrange_flag_n} = 3'h7;
		tEnd = -1000.0;
	end
	task automatic finish_conv();
		pending = 1'b0;
		doneN = 1'b0;
		readyIn = 1'b1;
		overrange_flag_n = ~over;
	endtask
	// stale timers are dropped by id
	task automatic finish_later(input int ns, input int myId);
		fork
			begin
				#(ns);
				if (pending && myId == id) finish_conv();
			end
		join_none
	endtask
	always @(negedge pins.wrN) if (modeHigh && !pins.csN) begin
		tWrFall = $realtime;
		if (tWrFall - tEnd < 500) faults++;
	end
	always @(posedge pins.wrN) if (modeHigh && !pins.csN) begin
		tWrRise = $realtime;
		if (tWrRise - tWrFall < 600 || tWrRise - tWrFall > 50000) faults++;
		held = analog[7:0];
		over = analog[8];
		pending = 1'b1;
		id++;
		finish_later(phaseNs, id);
	end
	always @(negedge pins.rdN) if (!pins.csN) begin
		if (modeHigh) begin
			if ($realtime - tWrRise < 600) faults++;
			if (pending) finish_conv();
		end else begin
			if ($realtime - tEnd < 500) faults++;
			held = analog[7:0];
			over = analog[8];
			pending = 1'b1;
			readyIn = 1'b0;
			id++;
			finish_later(2 * phaseNs, id);
		end
	end
	// re-zero starts when read is released
	always @(posedge pins.rdN) begin
		doneN = 1'b1;
		pending = 1'b0;
		readyIn = 1'b1;
		tEnd = $realtime;
	end
	// released bus shows the inverse, not stale data
	assign resultBus = (!pins.csN && !pins.rdN && !doneN) ? held : ~held;
endmodule

/* File: hfadc_host_tb.sv */
/*
 self-checking bench for the converter host sequencer.
 assumes hfadc_model on the far side and a 20 MHz ref_clk.
*/
module hfadc_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hfadc_pkg::*;
	logic ref_clk, srst, modeHigh, doneN, readyIn, overrange_flag_n, busy;
	hfadc_req_s req;
	hfadc_res_s res;
	hfadc_pins_s pins;
	logic [DATA_W-1:0] resultBus;
	logic [8:0] analog;
	int phaseNs, faults, nMismatch, checkCount, cycles, i;

	hfadc_host u_hfadc_host (
		.ref_clk(ref_clk), .srst(srst), .modeHigh(modeHigh), .req(req),
		.busy(busy), .res(res), .pins(pins), .resultBus(resultBus),
		.doneN(doneN), .readyIn(readyIn),
		.overrange_flag_n(overrange_flag_n)
	);
	hfadc_model u_hfadc_model (
		.pins(pins), .modeHigh(modeHigh), .analog(analog),
		.phaseNs(phaseNs), .resultBus(resultBus), .doneN(doneN),
		.readyIn(readyIn), .overrange_flag_n(overrange_flag_n),
		.faults(faults)
	);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checkCount, nMismatch);
		if (nMismatch == 0 && checkCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
		checkCount++;
		if (got !== exp) begin
			nMismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// result word the converter should hand back: timeout, overrange, data
	function automatic logic [9:0] exp_res(input logic [8:0] a, input logic to);
		return to ? 10'h200 : {1'b0, a};
	endfunction

	task automatic run_conv(input logic m, input logic e, input logic [8:0] a,
			input int ph, input logic to);
		int n;
		@(posedge ref_clk);
		modeHigh <= m;
		analog <= a;
		phaseNs <= ph;
		req <= '{start: 1'b1, early: e};
		@(posedge ref_clk);
		req <= '0;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (res.valid !== 1'b1 && n < 400);
		if (n >= 400) begin
			nMismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		end
		if (to) cmp({res.timeout, 9'h000}, exp_res(a, to));
		else cmp({res.timeout, res.overrange, res.data}, exp_res(a, to));
		cmp({9'h000, busy}, 10'h001);
		while (busy !== 1'b0 && n < 800) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		cmp({7'h00, pins}, 10'h007);
		$display("test done mode %0d early %0d value %h", m, e, a);
	endtask

	// hang guard: far above the fewer than two thousand cycles the tests need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			nMismatch++;
			end_sim();
		end
	end

	initial begin
		srst = 1'b1;
		modeHigh = 1'b1;
		req = '0;
		analog = '0;
		phaseNs = 800;
		cycles = 0;
		nMismatch = 0;
		checkCount = 0;
		void'($urandom(61210));
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		run_conv(1'b1, 1'b0, 9'h0a5, 800, 1'b0);
		run_conv(1'b1, 1'b1, 9'h100, 800, 1'b0);
		run_conv(1'b1, 1'b0, 9'h0ff, 200, 1'b0);
		run_conv(1'b0, 1'b0, 9'h13c, 800, 1'b0);
		run_conv(1'b0, 1'b0, 9'h055, 4000, 1'b1);
		run_conv(1'b0, 1'b0, 9'h1ff, 300, 1'b0);
		for (i = 0; i < 16; i++) begin
			run_conv(1'($urandom), 1'($urandom), 9'($urandom),
				200 + int'($urandom_range(1000)), 1'b0);
		end
		cmp(10'(faults), 10'h000);
		end_sim();
	end
endmodule
